/* File: hdl/acsg_channel_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module acsg_channel_ctrl
    import acsg_pkg::*;
#(
    parameter int N = 8
) (
    input  wire logic          clock_in,
    input  wire logic          rst_in,
    input  wire acsg_reg_req_t req_in,
    output logic [7:0]         rdata_out,
    input  wire logic          scan_begin_in,
    output logic [N-1:0]       scan_enable_out,
    output logic               auto_mode_out,
    output logic               scan_start_out,
    output acsg_mux_sel_t      manual_sel_out,
    input  wire logic [N-1:0]  pin_in,
    output logic [N-1:0]       pin_out,
    output logic [N-1:0]       pin_oe_out,
    output logic [N-1:0]       high_side_on_out,
    output logic [N-1:0]       low_side_on_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]   pin_func_r;
    logic [7:0]   direction_r;
    logic [7:0]   drive_type_r;
    logic [7:0]   out_level_r;
    logic [7:0]   seq_cfg_r;
    logic [7:0]   man_sel_r;
    logic [7:0]   scan_en_r;
    logic [N-1:0] scan_active_r;
    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [7:0]   rdata_nxt;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pin_func_r   <= RST_VALUE;
            direction_r  <= RST_VALUE;
            drive_type_r <= RST_VALUE;
            out_level_r  <= RST_VALUE;
            seq_cfg_r    <= RST_VALUE;
            man_sel_r    <= RST_VALUE;
            scan_en_r    <= RST_VALUE;
        end else if (req_in.write) begin
            case (req_in.addr)
                ADDR_PIN_FUNC:   pin_func_r   <= req_in.wdata;
                ADDR_DIRECTION:  direction_r  <= req_in.wdata;
                ADDR_DRIVE_TYPE: drive_type_r <= req_in.wdata;
                ADDR_OUT_LEVEL:  out_level_r  <= req_in.wdata;
                ADDR_SEQ_CFG:    seq_cfg_r    <= req_in.wdata & SEQ_CFG_MASK;
                ADDR_MAN_SEL:    man_sel_r    <= req_in.wdata & MAN_SEL_MASK;
                ADDR_SCAN_EN:    scan_en_r    <= req_in.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Scan set latched at sequence start
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            scan_active_r <= '0;
        end else if (scan_begin_in) begin
            scan_active_r <= scan_en_r[N-1:0];
        end
    end
    assign scan_enable_out = scan_active_r;
    assign auto_mode_out   = (seq_cfg_r[1:0] == MODE_AUTO);
    assign scan_start_out  = seq_cfg_r[SEQ_START_BIT];

    // ------------------------------------------------------------
    // Manual channel selection
    // ------------------------------------------------------------
    always_comb begin
        manual_sel_out.channel = man_sel_r[2:0];
        manual_sel_out.valid   = (seq_cfg_r[1:0] == MODE_MANUAL)
                               && (man_sel_r[3:0] <= CHID_MAX);
    end

    // ------------------------------------------------------------
    // Input sampling
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        case (req_in.addr)
            ADDR_PIN_FUNC:   rdata_nxt = pin_func_r;
            ADDR_DIRECTION:  rdata_nxt = direction_r;
            ADDR_DRIVE_TYPE: rdata_nxt = drive_type_r;
            ADDR_OUT_LEVEL:  rdata_nxt = out_level_r;
            ADDR_IN_LEVEL:   rdata_nxt = 8'(sync2_r & pin_func_r[N-1:0] & ~direction_r[N-1:0]);
            ADDR_SEQ_CFG:    rdata_nxt = seq_cfg_r;
            ADDR_MAN_SEL:    rdata_nxt = man_sel_r & MAN_SEL_MASK;
            ADDR_SCAN_EN:    rdata_nxt = scan_en_r;
            default:         rdata_nxt = RST_VALUE;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_out <= RST_VALUE;
        end else if (req_in.read) begin
            rdata_out <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    acsg_pin_driver #(
        .N (N)
    ) u_pins (
        .is_digital_in    (pin_func_r[N-1:0]),
        .is_output_in     (direction_r[N-1:0]),
        .push_pull_in     (drive_type_r[N-1:0]),
        .level_in         (out_level_r[N-1:0]),
        .pin_out          (pin_out),
        .pin_oe_out       (pin_oe_out),
        .high_side_on_out (high_side_on_out),
        .low_side_on_out  (low_side_on_out)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_mask_write;
        req_in.write && req_in.addr == ADDR_SCAN_EN && !scan_begin_in;
    endsequence

    a_man_upper_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        man_sel_r[7:4] == 4'h0) else $error("manual select upper bits not zero");
    a_reserved_id_invalid: assert property (@(posedge clock_in) disable iff (rst_in)
        man_sel_r[3] |-> !manual_sel_out.valid) else $error("reserved id selected a channel");
    a_manual_channel: assert property (@(posedge clock_in) disable iff (rst_in)
        manual_sel_out.valid |-> manual_sel_out.channel == man_sel_r[2:0])
        else $error("manual channel mismatch");
    a_mask_held: assert property (@(posedge clock_in) disable iff (rst_in)
        s_mask_write |=> $stable(scan_enable_out)) else $error("scan set changed mid scan");
    a_mask_load: assert property (@(posedge clock_in) disable iff (rst_in)
        scan_begin_in |=> scan_enable_out == $past(scan_en_r[N-1:0]))
        else $error("scan set not loaded");
    a_pp_one_side: assert property (@(posedge clock_in) disable iff (rst_in)
        (high_side_on_out & low_side_on_out) == '0) else $error("both drivers on");
    a_pp_drives: assert property (@(posedge clock_in) disable iff (rst_in)
        (pin_func_r[N-1:0] & direction_r[N-1:0] & drive_type_r[N-1:0] & ~pin_oe_out) == '0)
        else $error("push-pull pin floating");
    a_od_release: assert property (@(posedge clock_in) disable iff (rst_in)
        (~drive_type_r[N-1:0] & out_level_r[N-1:0] & pin_oe_out) == '0)
        else $error("open-drain pin driven high");
    a_od_pull_low: assert property (@(posedge clock_in) disable iff (rst_in)
        (pin_func_r[N-1:0] & direction_r[N-1:0] & ~out_level_r[N-1:0] & ~low_side_on_out) == '0)
        else $error("low not driven");

    // ------------------------------------------------------------
    // Readback and pin role checks
    // ------------------------------------------------------------
    sequence s_man_read;
        req_in.read && req_in.addr == ADDR_MAN_SEL;
    endsequence

    sequence s_scan_read;
        req_in.read && req_in.addr == ADDR_SCAN_EN;
    endsequence

    sequence s_in_read;
        req_in.read && req_in.addr == ADDR_IN_LEVEL;
    endsequence

    sequence s_scan_write;
        req_in.write && req_in.addr == ADDR_SCAN_EN;
    endsequence

    a_man_read_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        s_man_read |=> rdata_out[7:4] == 4'h0)
        else $error("manual select read upper set");
    a_scan_reset: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(rst_in) |-> scan_en_r == RST_VALUE && scan_enable_out == '0)
        else $error("scan mask not zero after reset");
    a_scan_readback: assert property (@(posedge clock_in) disable iff (rst_in)
        s_scan_read |=> rdata_out == $past(scan_en_r))
        else $error("scan mask readback wrong");
    a_scan_write: assert property (@(posedge clock_in) disable iff (rst_in)
        s_scan_write |=> scan_en_r == $past(req_in.wdata))
        else $error("scan mask write lost");
    a_in_level_read: assert property (@(posedge clock_in) disable iff (rst_in)
        s_in_read |=> ((rdata_out[N-1:0] ^ $past(sync2_r)) & $past(pin_func_r[N-1:0])
            & ~$past(direction_r[N-1:0])) == '0)
        else $error("input level readback wrong");
    a_in_analog_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        s_in_read |=> (rdata_out[N-1:0] & ~$past(pin_func_r[N-1:0])) == '0)
        else $error("analog pin read as set");
    a_in_output_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        s_in_read |=> (rdata_out[N-1:0] & $past(direction_r[N-1:0])) == '0)
        else $error("output pin read as set");
    a_analog_idle: assert property (@(posedge clock_in) disable iff (rst_in)
        (~pin_func_r[N-1:0] & (pin_oe_out | high_side_on_out | low_side_on_out)) == '0)
        else $error("analog pin driven");
    a_input_idle: assert property (@(posedge clock_in) disable iff (rst_in)
        (~direction_r[N-1:0] & (pin_oe_out | high_side_on_out | low_side_on_out)) == '0)
        else $error("digital input pin driven");
    a_od_no_source: assert property (@(posedge clock_in) disable iff (rst_in)
        (~drive_type_r[N-1:0] & high_side_on_out) == '0)
        else $error("open-drain pin sourcing");
    a_pp_one_on: assert property (@(posedge clock_in) disable iff (rst_in)
        (pin_func_r[N-1:0] & direction_r[N-1:0] & drive_type_r[N-1:0]
            & ~(high_side_on_out ^ low_side_on_out)) == '0)
        else $error("push-pull side count wrong");
    a_drive_level: assert property (@(posedge clock_in) disable iff (rst_in)
        (pin_oe_out & (pin_out ^ out_level_r[N-1:0])) == '0)
        else $error("driven level wrong");
    a_auto_excl: assert property (@(posedge clock_in) disable iff (rst_in)
        auto_mode_out |-> !manual_sel_out.valid)
        else $error("auto and manual both active");
    a_mode_reserved: assert property (@(posedge clock_in) disable iff (rst_in)
        seq_cfg_r[1] |-> !auto_mode_out && !manual_sel_out.valid)
        else $error("reserved mode selected a path");
    a_seq_cfg_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (seq_cfg_r & ~SEQ_CFG_MASK) == RST_VALUE)
        else $error("sequence config reserved bits set");

endmodule
`default_nettype wire

/* File: hdl/acsg_pkg.sv */
package acsg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PIN_FUNC   = 8'h05;
    localparam logic [7:0] ADDR_DIRECTION  = 8'h07;
    localparam logic [7:0] ADDR_DRIVE_TYPE = 8'h09;
    localparam logic [7:0] ADDR_OUT_LEVEL  = 8'h0b;
    localparam logic [7:0] ADDR_IN_LEVEL   = 8'h0d;
    localparam logic [7:0] ADDR_SEQ_CFG    = 8'h10;
    localparam logic [7:0] ADDR_MAN_SEL    = 8'h11;
    localparam logic [7:0] ADDR_SCAN_EN    = 8'h12;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_VALUE      = 8'h00;
    localparam logic [7:0] MAN_SEL_MASK   = 8'h0f;
    localparam logic [7:0] SEQ_CFG_MASK   = 8'h13;
    localparam int         SEQ_START_BIT  = 4;
    localparam logic [3:0] CHID_MAX       = 4'h7;
    localparam logic [1:0] MODE_MANUAL    = 2'h0;
    localparam logic [1:0] MODE_AUTO      = 2'h1;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } acsg_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] channel;
    } acsg_mux_sel_t;

endpackage

/* File: hdl/acsg_pin_driver.sv */
`timescale 1ns/1ns
`default_nettype none
module acsg_pin_driver
    import acsg_pkg::*;
#(
    parameter int N = 8
) (
    input  wire logic [N-1:0] is_digital_in,
    input  wire logic [N-1:0] is_output_in,
    input  wire logic [N-1:0] push_pull_in,
    input  wire logic [N-1:0] level_in,
    output logic [N-1:0]      pin_out,
    output logic [N-1:0]      pin_oe_out,
    output logic [N-1:0]      high_side_on_out,
    output logic [N-1:0]      low_side_on_out
);

    // ------------------------------------------------------------
    // Per-pin drive
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic drv;
        assign drv = is_digital_in[i] & is_output_in[i];
        assign high_side_on_out[i] = drv & push_pull_in[i] & level_in[i];
        assign low_side_on_out[i]  = drv & ~level_in[i];
        assign pin_oe_out[i] = drv & (push_pull_in[i] | ~level_in[i]);
        assign pin_out[i]    = drv & push_pull_in[i] & level_in[i];
    end

endmodule
`default_nettype wire

/* File: test/acsg_board_model.sv */
`timescale 1ns/1ns
`default_nettype none
module acsg_board_model #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] pin_out_in,
    input  wire logic [N-1:0] pin_oe_in,
    input  wire logic [N-1:0] ext_level_in,
    output logic [N-1:0]      pad_level_out
);
    // ------------------------------------------------------------
    // Pad resolution, released pins follow pull-up or source
    // ------------------------------------------------------------
    assign pad_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule
`default_nettype wire

/* File: test/adc_channel_select_gpio_mode_test.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_channel_select_gpio_mode_test;
    import acsg_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic          clock_in   = 1'b0;
    logic          rst_in     = 1'b1;
    acsg_reg_req_t req        = '0;
    logic          scan_begin = 1'b0;
    logic [7:0]    ext        = 8'h00;
    logic [7:0]    rdata, scan_en, pin_o, pin_oe, hi_on, lo_on, pad;
    logic          auto_mode, scan_start;
    acsg_mux_sel_t msel;
    int            err_count  = 0;
    int            compares   = 0;
    int            cycles     = 0;
    logic [31:0]   seed       = 32'h1435350c;
    logic [7:0]    v, f, d, t, l, q, m, e, last_m;
    logic [7:0]    addrs [9]  = '{ADDR_PIN_FUNC, ADDR_DIRECTION, ADDR_DRIVE_TYPE,
        ADDR_OUT_LEVEL, ADDR_IN_LEVEL, ADDR_SEQ_CFG, ADDR_MAN_SEL, ADDR_SCAN_EN, 8'h20};

    acsg_channel_ctrl #(.N(8)) dut_u (.clock_in(clock_in), .rst_in(rst_in), .req_in(req),
        .rdata_out(rdata), .scan_begin_in(scan_begin), .scan_enable_out(scan_en),
        .auto_mode_out(auto_mode), .scan_start_out(scan_start), .manual_sel_out(msel),
        .pin_in(pad), .pin_out(pin_o), .pin_oe_out(pin_oe), .high_side_on_out(hi_on),
        .low_side_on_out(lo_on));
    acsg_board_model #(.N(8)) board_u (.pin_out_in(pin_o), .pin_oe_in(pin_oe),
        .ext_level_in(ext), .pad_level_out(pad));

    always #2 clock_in = ~clock_in;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_oe(input logic [7:0] fn, input logic [7:0] dir,
                                          input logic [7:0] drv, input logic [7:0] lvl);
        return fn & dir & (drv | ~lvl);
    endfunction
    function automatic logic exp_valid(input logic [1:0] mode, input logic [3:0] id);
        return (mode == MODE_MANUAL) && (id <= CHID_MAX);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] w);
        @(posedge clock_in) req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: w};
        @(posedge clock_in) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge clock_in) req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock_in) req <= '0;
        #1 r = rdata;
    endtask
    task automatic print_verdict();
        if (err_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        foreach (addrs[i]) begin
            rd(addrs[i], q);
            chk(q, RST_VALUE);
        end
        chk(scan_en, 8'h00);
        wr(ADDR_SEQ_CFG, {6'h00, MODE_MANUAL});
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            v[3:0] = i[3:0];
            wr(ADDR_MAN_SEL, v);
            rd(ADDR_MAN_SEL, q);
            chk(q, v & MAN_SEL_MASK);
            chk(8'(msel.valid), 8'(exp_valid(MODE_MANUAL, v[3:0])));
            if (!v[3]) chk({5'h00, msel.channel}, {5'h00, v[2:0]});
        end
        wr(ADDR_MAN_SEL, 8'h03);
        for (int i = 0; i < 4; i++) begin
            v = (rnd() & 8'hfc) | i[7:0];
            wr(ADDR_SEQ_CFG, v);
            rd(ADDR_SEQ_CFG, q);
            chk(q, v & SEQ_CFG_MASK);
            chk({6'h00, auto_mode, scan_start}, {6'h00, i == 1, v[SEQ_START_BIT]});
            chk(8'(msel.valid), 8'(exp_valid(i[1:0], 4'h3)));
        end
        last_m = 8'h00;
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 8'hff : rnd();
            wr(ADDR_SCAN_EN, m);
            #1 chk(scan_en, last_m);
            @(posedge clock_in) scan_begin <= 1'b1;
            @(posedge clock_in) scan_begin <= 1'b0;
            #1 chk(scan_en, m);
            rd(ADDR_SCAN_EN, q);
            chk(q, m);
            last_m = m;
        end
        @(posedge clock_in) rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(ADDR_SCAN_EN, q);
        chk(q, RST_VALUE);
        chk(scan_en, 8'h00);
        for (int i = 0; i < 16; i++) begin
            f = (i < 2) ? 8'hff : rnd();
            d = (i < 2) ? 8'hff : rnd();
            t = (i == 0) ? 8'h00 : rnd();
            l = rnd();
            wr(ADDR_PIN_FUNC, f);
            wr(ADDR_DIRECTION, d);
            wr(ADDR_DRIVE_TYPE, t);
            wr(ADDR_OUT_LEVEL, l);
            @(posedge clock_in) ext <= rnd();
            repeat (4) @(posedge clock_in);
            #1 e = exp_oe(f, d, t, l);
            chk(pin_oe, e);
            chk(pin_o & e, l & e);
            chk(hi_on, f & d & t & l);
            chk(lo_on & f & d & t, f & d & t & ~l);
            chk(hi_on & lo_on, 8'h00);
            rd(ADDR_IN_LEVEL, q);
            chk(q, f & ~d & ext);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
